//--- hw/fcs_cfg.svh
// What this block does
// - Burst keeps the charge pump on only if next burst queued and same row.
// - A row is 64 bytes on address bits 5..0; zero there starts a row.
// - First burst byte and any new-row byte take standard time, others burst time.
// - No burst queued at byte end: pump off, high voltage removed.
// - No command is processed while the access error flag is set; writing one clears it.
// - Array write before the divider register was ever written sets the error.
// - Array write while the command buffer empty flag is clear sets the error.
// - Second array write or second command write before launch sets the error.
// - Wrong control register writes after array write or after command write set the error.
// - Any command code outside the five legal codes sets the error.
// - Stop mode during program or erase aborts it and sets the error.
// - Secured debug writes of program, burst or page erase codes set the error.
// - Writing zero to buffer empty flag cancels the partial command and sets error.
// - Protection blocks program and erase from a 512-byte boundary up to the top.
// - Protect register loads at reset; only debug writes change it.
// - Last unprotected address is select bits then ones; bit 0 low enables protection.
// - Partial protection without no-redirect moves interrupt vectors, never the reset vector.
// - Secured: flash and RAM blocked for unsecure code or debug; writes ignored except debug flash writes, reads zero.
// - Security from two option bits copied at reset; only 1:0 is unsecured.
// - The on-chip debug module cannot be enabled while secured.
// - Key mode turns key writes into compares; full in-order match unsecures until reset.
// - A debug blank check that passes unsecures until next reset.
// - Exactly five command codes are recognised, each with its fixed encoding.
// - Flash clock is bus clock, optionally over eight, divided by divisor plus one.
`ifndef FCS_CFG_SVH
`define FCS_CFG_SVH
// Control register addresses in high-page space
`define FCS_ADDR_CLKDIV 16'h1820
`define FCS_ADDR_OPTION 16'h1821
`define FCS_ADDR_CONFIG 16'h1823
`define FCS_ADDR_PROTECT 16'h1824
`define FCS_ADDR_STATUS 16'h1825
`define FCS_ADDR_COMMAND 16'h1826
// Nonvolatile copies and backdoor key
`define FCS_ADDR_NV_PROTECT 16'hFFBD
`define FCS_ADDR_NV_OPTION 16'hFFBF
`define FCS_KEY_BASE 16'hFFB0
`define FCS_KEY_LEN 4'h8
// Field positions
`define FCS_ST_CBEF 7
`define FCS_ST_CCF 6
`define FCS_ST_ACC 4
`define FCS_CFG_KEYMODE 5
`define FCS_OPT_PERMIT 7
`define FCS_OPT_NORED 6
`define FCS_PROT_DIS 0
`define FCS_DIV_LOADED 7
`define FCS_DIV_PRE8 6
`define FCS_ROW_BITS 6
`define FCS_PAGE_BITS 9
// Values
`define FCS_SEC_OPEN 2'h2
`define FCS_CMD_BLANK 8'h05
`define FCS_CMD_PROG 8'h20
`define FCS_CMD_BURST 8'h25
`define FCS_CMD_PAGE 8'h40
`define FCS_CMD_MASS 8'h41
`define FCS_VEC_LO 16'hFFC0
`define FCS_VEC_HI 16'hFFFD
// Operation lengths in flash clock ticks
`define FCS_TICKS_BYTE 9
`define FCS_TICKS_BURST 4
`define FCS_TICKS_PAGE 4000
`define FCS_TICKS_MASS 20000
`define FCS_TICKS_BLANK 4
`endif

//--- hw/fcs_pkg.sv
package fcs_pkg;
  typedef logic [7:0] fcs_byte_t;
  typedef logic [15:0] fcs_addr_t;
  // Command entry buffer
  typedef enum logic [2:0] {
    FCS_B_EMPTY = 3'b001,
    FCS_B_ADDR = 3'b010,
    FCS_B_CMD = 3'b100
  } fcs_buf_e;
  // Command executor
  typedef enum logic [1:0] {
    FCS_X_IDLE = 2'b01,
    FCS_X_RUN = 2'b10
  } fcs_exec_e;
endpackage

//--- hw/fcs_clkdiv.sv
`timescale 1ns/1ps
// Flash timing tick from the bus clock
module fcs_clkdiv #(
  parameter int DIV_W = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Setup
  input wire logic run,
  input wire logic pre8,
  input wire logic [DIV_W-1:0] divisor,
  // Tick out
  output logic tick
);
  logic [2:0] pre_ff;
  logic [DIV_W-1:0] cnt_ff;
  logic tick_ff;
  // Prescaler passes every edge or every eighth edge
  wire pre_tc = !pre8 || (pre_ff == 3'h7);
  wire cnt_tc = (cnt_ff == divisor);
  wire [2:0] nxt_pre = pre_ff + 3'h1;
  wire [DIV_W-1:0] nxt_cnt = cnt_tc ? '0 : cnt_ff + 1'b1;
  assign tick = tick_ff;
  // Divide by divisor plus one; held still until the divisor is loaded
  always_ff @(posedge clk) begin
    if (!nrst || !run) begin
      pre_ff <= 3'h0;
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      pre_ff <= nxt_pre;
      if (pre_tc) begin
        cnt_ff <= nxt_cnt;
      end
      tick_ff <= pre_tc && cnt_tc;
    end
  end
endmodule

//--- hw/fcs_ctrl.sv
`timescale 1ns/1ps
`include "fcs_cfg.svh"
// Flash command sequencer with protection and security
module fcs_ctrl
  import fcs_pkg::*;
#(
  parameter fcs_addr_t FLASH_BASE = 16'h8000,
  parameter fcs_addr_t RAM_BASE = 16'h0080,
  parameter fcs_addr_t RAM_TOP = 16'h07FF,
  parameter int unsigned BYTE_TICKS = `FCS_TICKS_BYTE,
  parameter int unsigned BURST_TICKS = `FCS_TICKS_BURST,
  parameter int unsigned PAGE_TICKS = `FCS_TICKS_PAGE,
  parameter int unsigned MASS_TICKS = `FCS_TICKS_MASS,
  parameter int unsigned BLANK_TICKS = `FCS_TICKS_BLANK
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Nonvolatile copies
  input wire logic [7:0] nv_prot,
  input wire logic [7:0] nv_opt,
  input wire logic [63:0] nv_key,
  // CPU and debug access
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_dbg,
  input wire logic bus_secure_code,
  output logic [7:0] bus_rdata,
  // Memory path
  input wire logic [7:0] mem_rdata,
  output logic mem_block,
  // Vector fetch
  input wire logic [15:0] vec_addr_in,
  output logic [15:0] vec_addr_out,
  // Flash array
  input wire logic arr_blank,
  output logic [15:0] arr_addr,
  output logic [7:0] arr_data,
  output logic arr_pump,
  output logic arr_prog,
  output logic arr_page_erase,
  output logic arr_mass_erase,
  output logic arr_verify,
  output logic arr_commit,
  // System
  input wire logic stop_req,
  output logic secured,
  output logic dbg_module_allow
);
  localparam int CW = 15;

  fcs_buf_e buf_ff, nxt_buf;
  fcs_exec_e ex_ff;
  logic acc_ff, pend_ff, pump_ff, commit_ff;

  logic divld_ff, pre8_ff;
  logic [5:0] divisor_ff;

  logic [7:0] prot_ff, opt_ff;
  logic keymode_ff, key_ok_ff;
  logic [3:0] key_idx_ff;

  fcs_addr_t baddr_ff, caddr_ff;
  fcs_byte_t bdata_ff, cdata_ff, bcmd_ff, ccmd_ff;
  logic bdbg_ff, cdbg_ff;

  logic [CW-1:0] cnt_ff;
  logic [7:0] rdata_ff;
  logic tick;

  // Legal command codes
  function automatic logic cmd_legal(input fcs_byte_t c);
    cmd_legal = (c == `FCS_CMD_BLANK) || (c == `FCS_CMD_PROG) || (c == `FCS_CMD_BURST) ||
                (c == `FCS_CMD_PAGE) || (c == `FCS_CMD_MASS);
  endfunction

  // Operation length in flash ticks; standard time unless burst continuation
  function automatic logic [CW-1:0] op_ticks(input fcs_byte_t c);
    if (c == `FCS_CMD_PAGE) op_ticks = CW'(PAGE_TICKS);
    else if (c == `FCS_CMD_MASS) op_ticks = CW'(MASS_TICKS);
    else if (c == `FCS_CMD_BLANK) op_ticks = CW'(BLANK_TICKS);
    else op_ticks = CW'(BYTE_TICKS);
  endfunction

  // Protection decode
  wire prot_en = !prot_ff[`FCS_PROT_DIS];
  wire [15:0] last_open = {prot_ff[7:1], {`FCS_PAGE_BITS{1'b1}}};
  wire prot_full = last_open < FLASH_BASE;
  wire addr_prot = prot_en && (baddr_ff > last_open);

  // Security state
  assign secured = opt_ff[1:0] != `FCS_SEC_OPEN;
  assign dbg_module_allow = !secured;

  // Address decode
  wire is_flash = bus_addr >= FLASH_BASE;
  wire is_ram = (bus_addr >= RAM_BASE) && (bus_addr <= RAM_TOP);
  wire hit_div = bus_addr == `FCS_ADDR_CLKDIV;
  wire hit_opt = bus_addr == `FCS_ADDR_OPTION;
  wire hit_cfg = bus_addr == `FCS_ADDR_CONFIG;
  wire hit_prot = bus_addr == `FCS_ADDR_PROTECT;
  wire hit_stat = bus_addr == `FCS_ADDR_STATUS;
  wire hit_cmd = bus_addr == `FCS_ADDR_COMMAND;
  wire hit_reg = hit_div || hit_opt || hit_cfg || hit_prot || hit_stat || hit_cmd;

  // Secure memory gating for unsecure code and debug
  assign mem_block = secured && (bus_dbg || !bus_secure_code) && (is_flash || is_ram);

  // Write strobes
  // Debug array writes remain command steps
  wire arr_wr = bus_wr && is_flash && (!mem_block || bus_dbg);
  wire key_wr = arr_wr && keymode_ff;
  wire cmd_arr = arr_wr && !keymode_ff;
  wire wr_div = bus_wr && hit_div;
  wire wr_cfg = bus_wr && hit_cfg;
  wire wr_prot = bus_wr && hit_prot;
  wire wr_stat = bus_wr && hit_stat;
  wire wr_cmd = bus_wr && hit_cmd;
  wire wr_ctl = bus_wr && hit_reg;

  wire in_empty = buf_ff == FCS_B_EMPTY;
  wire in_addr = buf_ff == FCS_B_ADDR;
  wire in_cmd = buf_ff == FCS_B_CMD;
  wire launch = wr_stat && bus_wdata[`FCS_ST_CBEF] && in_cmd && !acc_ff;
  wire run = ex_ff == FCS_X_RUN;

  // Command code checks on entry
  wire code_bad = !cmd_legal(bus_wdata);
  wire code_dbg_bad = bus_dbg && secured && ((bus_wdata == `FCS_CMD_PROG) ||
                      (bus_wdata == `FCS_CMD_BURST) || (bus_wdata == `FCS_CMD_PAGE));
  wire code_prot = (bus_wdata == `FCS_CMD_MASS) ? prot_en :
                   ((bus_wdata != `FCS_CMD_BLANK) && addr_prot);

  // Access error causes
  wire e_nodiv = cmd_arr && !divld_ff;
  wire e_busy = cmd_arr && pend_ff;
  wire e_dup_arr = cmd_arr && !in_empty;
  wire e_dup_cmd = wr_cmd && (in_cmd || in_empty);
  wire e_ctl_addr = wr_ctl && !hit_cmd && in_addr;
  wire e_ctl_cmd = wr_ctl && !hit_stat && !hit_cmd && in_cmd;
  wire e_code = wr_cmd && in_addr && (code_bad || code_dbg_bad || code_prot);
  wire e_abort = wr_stat && !bus_wdata[`FCS_ST_CBEF] && in_cmd;

  wire e_stop = stop_req && run;
  wire e_entry = e_nodiv || e_busy || e_dup_arr || e_dup_cmd ||
                 e_ctl_addr || e_ctl_cmd || e_code || e_abort;
  wire acc_set = e_entry || e_stop;
  wire acc_clr = wr_stat && bus_wdata[`FCS_ST_ACC];
  wire nxt_acc = acc_set || (acc_ff && !acc_clr);

  // Entry buffer next state; any violation drops the partial command
  always_comb begin
    nxt_buf = buf_ff;
    if (e_entry || acc_ff) begin
      nxt_buf = FCS_B_EMPTY;
    end else begin
      unique case (buf_ff)
        FCS_B_EMPTY: if (cmd_arr) nxt_buf = FCS_B_ADDR;
        FCS_B_ADDR: if (wr_cmd) nxt_buf = FCS_B_CMD;
        FCS_B_CMD: if (launch) nxt_buf = FCS_B_EMPTY;
        default: nxt_buf = FCS_B_EMPTY;
      endcase
    end
  end

  // Entry buffer and latched command
  always_ff @(posedge clk) begin
    if (!nrst) begin
      buf_ff <= FCS_B_EMPTY;
      acc_ff <= 1'b0;
      baddr_ff <= 16'h0000;
      bdata_ff <= 8'h00;
      bcmd_ff <= 8'h00;
      bdbg_ff <= 1'b0;
    end else begin
      buf_ff <= nxt_buf;
      acc_ff <= nxt_acc;
      if (in_empty && cmd_arr && !acc_ff) begin
        baddr_ff <= bus_addr;
        bdata_ff <= bus_wdata;
      end
      if (in_addr && wr_cmd) begin
        bcmd_ff <= bus_wdata;
        bdbg_ff <= bus_dbg;
      end
    end
  end

  // Executor decode
  wire op_end = run && tick && (cnt_ff == CW'(1));
  wire burst_keep = (ccmd_ff == `FCS_CMD_BURST) && pend_ff && (bcmd_ff == `FCS_CMD_BURST) &&
                    (baddr_ff[15:`FCS_ROW_BITS] == caddr_ff[15:`FCS_ROW_BITS]);
  wire start = !run && pend_ff && !stop_req;
  wire keep = op_end && burst_keep && !stop_req;
  wire take = start || keep;
  wire blank_pass = op_end && (ccmd_ff == `FCS_CMD_BLANK) && cdbg_ff && arr_blank;

  wire [CW-1:0] nxt_cnt = start ? op_ticks(bcmd_ff) :
                          keep ? CW'(BURST_TICKS) :
                          (run && tick) ? cnt_ff - CW'(1) : cnt_ff;

  // Executor; one byte or erase at a time, next burst byte queued in the buffer
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ex_ff <= FCS_X_IDLE;
      pend_ff <= 1'b0;
      pump_ff <= 1'b0;
      commit_ff <= 1'b0;
      cnt_ff <= '0;
      caddr_ff <= 16'h0000;
      cdata_ff <= 8'h00;
      ccmd_ff <= 8'h00;
      cdbg_ff <= 1'b0;
    end else begin
      commit_ff <= op_end && !stop_req;
      cnt_ff <= nxt_cnt;
      if (launch) pend_ff <= 1'b1;
      else if (take || e_stop) pend_ff <= 1'b0;
      if (take) begin
        caddr_ff <= baddr_ff;
        cdata_ff <= bdata_ff;
        ccmd_ff <= bcmd_ff;
        cdbg_ff <= bdbg_ff;
      end
      if (e_stop) begin
        ex_ff <= FCS_X_IDLE;
        pump_ff <= 1'b0;
      end else if (start) begin
        ex_ff <= FCS_X_RUN;
        pump_ff <= 1'b1;
      end else if (op_end && !keep) begin
        ex_ff <= FCS_X_IDLE;
        pump_ff <= 1'b0;
      end
    end
  end

  // Array controls follow the running command
  assign arr_addr = caddr_ff;
  assign arr_data = cdata_ff;
  assign arr_pump = pump_ff;
  assign arr_commit = commit_ff;
  assign arr_prog = run && ((ccmd_ff == `FCS_CMD_PROG) || (ccmd_ff == `FCS_CMD_BURST));
  assign arr_page_erase = run && (ccmd_ff == `FCS_CMD_PAGE);
  assign arr_mass_erase = run && (ccmd_ff == `FCS_CMD_MASS);
  assign arr_verify = run && (ccmd_ff == `FCS_CMD_BLANK);

  // Backdoor key compare decode
  wire key_in_order = (bus_addr == (`FCS_KEY_BASE + {12'h000, key_idx_ff})) && (key_idx_ff < `FCS_KEY_LEN);
  wire key_byte_ok = key_in_order && bus_secure_code && !bus_dbg &&
                     (bus_wdata == nv_key[{key_idx_ff[2:0], 3'h0} +: 8]);
  wire key_enter = wr_cfg && bus_wdata[`FCS_CFG_KEYMODE] && opt_ff[`FCS_OPT_PERMIT];
  wire key_leave = wr_cfg && !bus_wdata[`FCS_CFG_KEYMODE] && keymode_ff;
  wire key_match = key_leave && key_ok_ff && (key_idx_ff == `FCS_KEY_LEN);

  // Key mode state; a wrong or out-of-order byte spoils the whole key
  always_ff @(posedge clk) begin
    if (!nrst) begin
      keymode_ff <= 1'b0;
      key_ok_ff <= 1'b0;
      key_idx_ff <= 4'h0;
    end else if (key_enter && !keymode_ff) begin
      keymode_ff <= 1'b1;
      key_ok_ff <= 1'b1;
      key_idx_ff <= 4'h0;
    end else if (key_leave) begin
      keymode_ff <= 1'b0;
    end else if (key_wr) begin
      key_ok_ff <= key_ok_ff && key_byte_ok;
      key_idx_ff <= (key_idx_ff < `FCS_KEY_LEN) ? key_idx_ff + 4'h1 : key_idx_ff;
    end
  end

  // Working option and protect copies, caught while reset is held
  always_ff @(posedge clk) begin
    if (!nrst) begin
      opt_ff <= nv_opt;
      prot_ff <= nv_prot;
    end else begin
      if (key_match || blank_pass) begin
        opt_ff[1:0] <= `FCS_SEC_OPEN;
      end
      if (wr_prot && bus_dbg && !acc_set) begin
        prot_ff <= bus_wdata;
      end
    end
  end

  // Divider setup, writable once; refused while the error flag is up
  always_ff @(posedge clk) begin
    if (!nrst) begin
      divld_ff <= 1'b0;
      pre8_ff <= 1'b0;
      divisor_ff <= 6'h00;
    end else if (wr_div && !divld_ff && !acc_ff && !acc_set) begin
      divld_ff <= 1'b1;
      pre8_ff <= bus_wdata[`FCS_DIV_PRE8];
      divisor_ff <= bus_wdata[5:0];
    end
  end

  fcs_clkdiv #(
    .DIV_W(6)
  ) u_clkdiv (
    .clk(clk),
    .nrst(nrst),
    .run(divld_ff),
    .pre8(pre8_ff),
    .divisor(divisor_ff),
    .tick(tick)
  );

  // Register and memory read data
  wire cbef = !pend_ff;
  wire ccf = !run && !pend_ff;
  wire [7:0] stat_val = {cbef, ccf, 1'b0, acc_ff, 4'h0};
  wire [7:0] reg_val = hit_div ? {divld_ff, pre8_ff, divisor_ff} :
                       hit_opt ? opt_ff :
                       hit_cfg ? {2'h0, keymode_ff, 5'h00} :
                       hit_prot ? prot_ff :
                       hit_stat ? stat_val : 8'h00;
  wire [7:0] nxt_rdata = hit_reg ? reg_val :
                         mem_block ? 8'h00 : mem_rdata;
  assign bus_rdata = rdata_ff;

  // Read data held until the next read
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_ff <= 8'h00;
    end else if (bus_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Vector redirection under partial protection
  wire vec_hit = (vec_addr_in >= `FCS_VEC_LO) && (vec_addr_in <= `FCS_VEC_HI);
  wire vec_move = !opt_ff[`FCS_OPT_NORED] && prot_en && !prot_full && vec_hit;
  assign vec_addr_out = vec_move ? {last_open[15:`FCS_ROW_BITS], vec_addr_in[`FCS_ROW_BITS-1:0]} :
                        vec_addr_in;
endmodule

//--- test/fcs_ctrl_chk.sv
`timescale 1ns/1ps
`include "fcs_cfg.svh"
// Port-level properties of the flash sequencer
module fcs_ctrl_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Nonvolatile copies and bus
  input wire logic [7:0] nv_prot,
  input wire logic [7:0] nv_opt,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_dbg,
  input wire logic bus_secure_code,
  input wire logic [7:0] bus_rdata,
  input wire logic mem_block,
  // Vectors, array and system
  input wire logic [15:0] vec_addr_in,
  input wire logic [15:0] vec_addr_out,
  input wire logic arr_pump,
  input wire logic arr_prog,
  input wire logic arr_page_erase,
  input wire logic arr_mass_erase,
  input wire logic arr_verify,
  input wire logic arr_commit,
  input wire logic stop_req,
  input wire logic secured,
  input wire logic dbg_module_allow
);
  logic [7:0] prot_ff;
  logic [7:0] opt_ff;
  logic [15:0] last_open;
  logic redir;
  logic busy;
  // Shadow copies; debug may rewrite protection later
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prot_ff <= nv_prot;
      opt_ff <= nv_opt;
    end else if (bus_wr && bus_dbg && bus_addr == `FCS_ADDR_PROTECT) begin
      prot_ff <= bus_wdata;
    end
  end
  // Expected vector remap
  assign last_open = {prot_ff[7:1], 9'h1FF};
  assign redir = !opt_ff[6] && !prot_ff[0] && last_open >= 16'h8000 && vec_addr_in >= `FCS_VEC_LO &&
    vec_addr_in <= `FCS_VEC_HI;
  assign busy = arr_prog || arr_page_erase || arr_mass_erase || arr_verify;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  AST_VEC_MAP: assert property (vec_addr_out == (redir ? {last_open[15:6], vec_addr_in[5:0]} : vec_addr_in))
    else $error("vector remap differs");
  AST_DBG_ALLOW: assert property (dbg_module_allow == !secured)
    else $error("debug module allowed while locked");
  AST_SEC_RESET: assert property ($rose(nrst) |-> secured == (opt_ff[1:0] != `FCS_SEC_OPEN))
    else $error("lock state not taken from option byte");
  AST_SEC_HOLD: assert property (!secured |=> !secured)
    else $error("lock returned without reset");
  AST_BLOCK: assert property ((bus_rd || bus_wr) && secured && (bus_dbg || !bus_secure_code) &&
    bus_addr >= 16'h8000 |-> mem_block)
    else $error("locked access not blocked");
  AST_OPEN: assert property (!secured |-> !mem_block)
    else $error("access blocked while open");
  AST_RD_ZERO: assert property (bus_rd && mem_block |=> bus_rdata == 8'h00)
    else $error("blocked read not zero");
  AST_PUMP_OP: assert property ((arr_prog || arr_page_erase || arr_mass_erase) |-> arr_pump)
    else $error("array op without pump");
  AST_PUMP_IDLE: assert property (!busy |-> !arr_pump)
    else $error("pump on while idle");
  AST_STOP: assert property (stop_req |-> ##[1:2] !arr_pump)
    else $error("pump kept on in stop");
  // Main scenarios reached
  cover property ($fell(secured));
  cover property (arr_commit);
  cover property (redir);
endmodule

bind fcs_ctrl fcs_ctrl_chk u_chk (
  .clk(clk), .nrst(nrst), .nv_prot(nv_prot), .nv_opt(nv_opt), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_dbg(bus_dbg), .bus_secure_code(bus_secure_code),
  .bus_rdata(bus_rdata), .mem_block(mem_block), .vec_addr_in(vec_addr_in), .vec_addr_out(vec_addr_out),
  .arr_pump(arr_pump), .arr_prog(arr_prog), .arr_page_erase(arr_page_erase), .arr_mass_erase(arr_mass_erase),
  .arr_verify(arr_verify), .arr_commit(arr_commit), .stop_req(stop_req), .secured(secured),
  .dbg_module_allow(dbg_module_allow)
);

//--- test/fcs_host_model.sv
`timescale 1ns/1ps
`include "fcs_cfg.svh"
// CPU and background debug side of the flash bus
module fcs_host_model (
  // Clock and read data
  input wire logic clk,
  input wire logic [7:0] rdata,
  // Strobes and qualifiers
  output logic wr,
  output logic rd,
  output logic [15:0] addr,
  output logic [7:0] wdata,
  output logic dbg,
  output logic sec_code
);
  logic sel_dbg;
  initial begin
    sel_dbg = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 16'h0000;
    wdata = 8'h00;
    dbg = 1'b0;
    sec_code = 1'b1;
  end
  // One access held to its edge; idle lines inverted
  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    #1;
    wr = w;
    rd = !w;
    addr = a;
    wdata = d;
    dbg = sel_dbg;
    @(posedge clk);
    #1;
    q = rdata;
    wr = 1'b0;
    rd = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask
  // Launch a fully entered command
  task automatic launch;
    logic [7:0] q;
    xfer(1'b1, `FCS_ADDR_STATUS, 8'h80, q);
  endtask
  // Clear the access error by writing one to it
  task automatic clear_err;
    logic [7:0] q;
    xfer(1'b1, `FCS_ADDR_STATUS, 8'h10, q);
  endtask
endmodule

//--- test/testbench.sv
`timescale 1ns/1ps
`include "fcs_cfg.svh"
// Self-checking bench for the flash sequencer
module testbench;
  localparam logic [63:0] KEY = 64'h0F1E2D3C4B5A6978;
  localparam int DV = 4;
  logic clk, nrst, bus_wr, bus_rd, bus_dbg, bus_secure_code, arr_blank, stop_req;
  logic [7:0] nv_prot, nv_opt, bus_wdata, bus_rdata, mem_rdata, arr_data;
  logic [15:0] bus_addr, vec_addr_in, vec_addr_out, arr_addr;
  logic mem_block, arr_pump, arr_prog, arr_page_erase, arr_mass_erase, arr_verify, arr_commit;
  logic secured, dbg_module_allow;
  int err_count = 0;
  int checks_done = 0;
  int commits = 0;
  int run_len = 0;
  int runs[$];
  // Short erase counts keep the run brief
  fcs_ctrl #(.PAGE_TICKS(8), .MASS_TICKS(12)) uut (
    .clk(clk), .nrst(nrst), .nv_prot(nv_prot), .nv_opt(nv_opt), .nv_key(KEY), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_dbg(bus_dbg),
    .bus_secure_code(bus_secure_code), .bus_rdata(bus_rdata), .mem_rdata(mem_rdata), .mem_block(mem_block),
    .vec_addr_in(vec_addr_in), .vec_addr_out(vec_addr_out), .arr_blank(arr_blank), .arr_addr(arr_addr),
    .arr_data(arr_data), .arr_pump(arr_pump), .arr_prog(arr_prog), .arr_page_erase(arr_page_erase),
    .arr_mass_erase(arr_mass_erase), .arr_verify(arr_verify), .arr_commit(arr_commit), .stop_req(stop_req),
    .secured(secured), .dbg_module_allow(dbg_module_allow)
  );
  fcs_host_model host (
    .clk(clk), .rdata(bus_rdata), .wr(bus_wr), .rd(bus_rd), .addr(bus_addr), .wdata(bus_wdata),
    .dbg(bus_dbg), .sec_code(bus_secure_code)
  );
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Pump stretches and commit pulses at the array
  always @(posedge clk) begin
    if (arr_commit) begin
      commits++;
    end
    if (arr_pump) begin
      run_len++;
    end else if (run_len != 0) begin
      runs.push_back(run_len);
      run_len = 0;
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] q);
    host.xfer(1'b0, a, 8'h00, q);
  endtask
  task automatic cmd(input logic [15:0] a, input logic [7:0] c);
    wr(a, 8'h55);
    wr(`FCS_ADDR_COMMAND, c);
    host.launch();
  endtask
  // Poll status until all bits of m are set, bounded
  task automatic wait_st(input logic [7:0] m);
    logic [7:0] q;
    q = 8'h00;
    for (int i = 0; i < 100 && (q & m) != m; i++) begin
      rd(`FCS_ADDR_STATUS, q);
    end
    check(q & m, m);
  endtask
  task automatic acc_chk(input logic e);
    logic [7:0] q;
    rd(`FCS_ADDR_STATUS, q);
    check(q[4], e);
    if (q[4]) begin
      host.clear_err();
    end
  endtask
  task automatic err_case(input logic [15:0] a, input logic [7:0] c, input logic [15:0] a2, input logic [7:0] d2);
    wr(a, 8'h55);
    if (c != 8'h00) begin
      wr(`FCS_ADDR_COMMAND, c);
    end
    wr(a2, d2);
    acc_chk(1'b1);
  endtask
  task automatic t_secure;
    logic [7:0] q;
    check(secured, 1'b1);
    check(dbg_module_allow, 1'b0);
    check(vec_addr_out, 16'hFDE8);
    vec_addr_in = 16'hFFFE;
    #1;
    check(vec_addr_out, 16'hFFFE);
    host.sel_dbg = 1'b1;
    rd(16'h9000, q);
    check(q, 8'h00);
    host.sel_dbg = 1'b0;
    rd(16'h9000, q);
    check(q, 8'h5A);
  endtask
  task automatic t_errors;
    logic [7:0] q;
    logic [7:0] codes [4] = '{`FCS_CMD_BLANK, `FCS_CMD_PROG, `FCS_CMD_BURST, `FCS_CMD_PAGE};
    int n;
    wr(16'h9000, 8'h55);
    acc_chk(1'b1);
    wr(`FCS_ADDR_CLKDIV, 8'h03);
    wr(`FCS_ADDR_CLKDIV, 8'h3F);
    rd(`FCS_ADDR_CLKDIV, q);
    check(q, 8'h83);
    wr(16'h9000, 8'h55);
    wr(16'h9001, 8'h55);
    cmd(16'h9000, `FCS_CMD_PROG);
    check(arr_prog, 1'b0);
    acc_chk(1'b1);
    err_case(16'h9000, 8'h00, `FCS_ADDR_CONFIG, 8'h00);
    err_case(16'h9000, 8'h00, `FCS_ADDR_STATUS, 8'h80);
    err_case(16'h9000, 8'h20, `FCS_ADDR_COMMAND, 8'h20);
    err_case(16'h9000, 8'h20, `FCS_ADDR_CONFIG, 8'h00);
    err_case(16'h9000, 8'h00, `FCS_ADDR_COMMAND, 8'h21);
    err_case(16'h9000, 8'h20, `FCS_ADDR_STATUS, 8'h00);
    err_case(16'hFE00, 8'h20, `FCS_ADDR_STATUS, 8'h80);
    err_case(16'hFFFF, 8'h40, `FCS_ADDR_STATUS, 8'h80);
    err_case(16'h9000, 8'h41, `FCS_ADDR_STATUS, 8'h80);
    cmd(16'h9000, `FCS_CMD_PROG);
    cmd(16'h9002, `FCS_CMD_PROG);
    wr(16'h9004, 8'h55);
    acc_chk(1'b1);
    wait_st(8'hC0);
    cmd(16'hFDFF, `FCS_CMD_PROG);
    wait_st(8'hC0);
    acc_chk(1'b0);
    foreach (codes[i]) begin
      n = commits;
      cmd(16'h9000, codes[i]);
      wait_st(8'hC0);
      acc_chk(1'b0);
      check(16'(commits - n), 16'h0001);
    end
  endtask
  // Tick phase may shift a stretch by up to one divider period
  task automatic t_burst;
    runs.delete();
    cmd(16'h903E, `FCS_CMD_BURST);
    cmd(16'h903F, `FCS_CMD_BURST);
    wait_st(8'h80);
    cmd(16'h9040, `FCS_CMD_BURST);
    wait_st(8'hC0);
    check(16'(runs.size()), 16'h0002);
    check(runs[0] inside {[13*DV-DV:13*DV+DV]}, 1'b1);
    check(runs[1] inside {[9*DV-DV:9*DV+DV]}, 1'b1);
    check(arr_addr, 16'h9040);
    check(arr_data, 16'h0055);
  endtask
  task automatic t_stop;
    int n;
    cmd(16'h9000, `FCS_CMD_PAGE);
    repeat (4) @(posedge clk);
    #1;
    n = commits;
    stop_req = 1'b1;
    @(posedge clk);
    #1;
    stop_req = 1'b0;
    repeat (40) @(posedge clk);
    #1;
    check(16'(commits - n), 16'h0000);
    check(arr_pump, 1'b0);
    acc_chk(1'b1);
  endtask
  task automatic t_protect;
    logic [7:0] q;
    logic [7:0] dcodes [3] = '{`FCS_CMD_PROG, `FCS_CMD_BURST, `FCS_CMD_PAGE};
    wr(`FCS_ADDR_PROTECT, 8'hFF);
    rd(`FCS_ADDR_PROTECT, q);
    check(q, 8'hFC);
    host.sel_dbg = 1'b1;
    wr(`FCS_ADDR_PROTECT, 8'hFF);
    rd(`FCS_ADDR_PROTECT, q);
    check(q, 8'hFF);
    vec_addr_in = 16'hFFE8;
    #1;
    check(vec_addr_out, 16'hFFE8);
    foreach (dcodes[i]) begin
      err_case(16'h9000, dcodes[i], `FCS_ADDR_STATUS, 8'h80);
    end
    cmd(16'h9000, `FCS_CMD_MASS);
    wait_st(8'hC0);
    acc_chk(1'b0);
    host.sel_dbg = 1'b0;
  endtask
  // Key compare; writes are spaced so no two are adjacent
  task automatic key_try(input logic [7:0] flip, input logic exp);
    wr(`FCS_ADDR_CONFIG, 8'h20);
    for (int k = 0; k < 8; k++) begin
      wr(`FCS_KEY_BASE + 16'(k), KEY[8*k +: 8] ^ (k == 7 ? flip : 8'h00));
    end
    wr(`FCS_ADDR_CONFIG, 8'h00);
    @(posedge clk);
    #1;
    check(secured, exp);
  endtask
  task automatic t_blank;
    nrst = 1'b0;
    nv_prot = 8'hFF;
    repeat (2) @(posedge clk);
    #1;
    nrst = 1'b1;
    check(secured, 1'b1);
    wr(`FCS_ADDR_CLKDIV, 8'h03);
    host.sel_dbg = 1'b1;
    arr_blank = 1'b1;
    cmd(16'h9000, `FCS_CMD_BLANK);
    wait_st(8'hC0);
    check(secured, 1'b0);
    host.sel_dbg = 1'b0;
  endtask
  task automatic test_done;
    if (err_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    logic [7:0] q;
    nrst = 1'b0;
    nv_prot = 8'hFC;
    nv_opt = 8'h83;
    mem_rdata = 8'h5A;
    arr_blank = 1'b0;
    stop_req = 1'b0;
    vec_addr_in = 16'hFFE8;
    repeat (16) @(posedge clk);
    #1;
    nrst = 1'b1;
    t_secure();
    t_errors();
    t_burst();
    t_stop();
    t_protect();
    key_try(8'h01, 1'b1);
    key_try(8'h00, 1'b0);
    check(dbg_module_allow, 1'b1);
    t_blank();
    test_done();
  end
  // Watchdog far beyond the run
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    test_done();
  end
endmodule
